/* File: test/rtc_event_user.sv */
// Purpose: far side model: RTC tick source and event user
// Assumes: one tick every four clk cycles while run is high
// Notes:   phase restarts per burst so tick counts are exact
`timescale 1ns/1ps
module rtc_event_user (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    input  wire logic overflow_event,
    input  wire logic compare_match_event,
    output logic      rtc_tick,
    output int        ovf_n,
    output int        cmp_n
);
    logic [1:0] phase_reg;
    assign rtc_tick = run && (phase_reg == 2'h3);
    // tick phase and event tally
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= 2'h0;
            ovf_n <= 0;
            cmp_n <= 0;
        end else begin
            phase_reg <= run ? phase_reg + 2'h1 : 2'h0;
            ovf_n <= ovf_n + int'(overflow_event); // one pulse, one event
            cmp_n <= cmp_n + int'(compare_match_event);
        end
    end
endmodule : rtc_event_user

/* File: test/rtc_prescaler_pit_properties.sv */
// Purpose: concurrent checks on event, periodic and interrupt outputs
// Assumes: rtc_tick pulses no closer than every other clk cycle
// Notes:   bound to every rtc_prescaler_pit instance
`timescale 1ns/1ps
module rtc_prescaler_pit_properties (
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire logic                      rtc_tick,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [7:0]                wb_adr_i,
    input wire logic [3:0]                wb_sel_i,
    input wire logic [31:0]               wb_dat_i,
    input wire logic [31:0]               wb_dat_o,
    input wire logic                      wb_ack_o,
    input wire logic                      irq,
    input wire logic                      overflow_event,
    input wire logic                      compare_match_event,
    input wire logic [rtc_pkg::EVT_N-1:0] div_level_event,
    input wire logic                      periodic_interrupt_timer
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    AST_OVF_PULSE: assert property (overflow_event |=> !overflow_event)
        else $error("overflow event wider than one cycle");
    AST_CMP_PULSE: assert property (compare_match_event |=> !compare_match_event)
        else $error("compare event wider than one cycle");
    AST_OVF_TICK: assert property (overflow_event |-> $past(rtc_tick) || $past(rtc_tick, 2))
        else $error("overflow event without a tick");
    AST_CMP_TICK: assert property (compare_match_event |-> $past(rtc_tick) || $past(rtc_tick, 2))
        else $error("compare event without a tick");
    AST_DIV_CAUSE: assert property ($changed(div_level_event) |-> $past(rtc_tick)
        || $past(rtc_tick, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2))
        else $error("divided level moved without a tick");
    AST_PIT_CAUSE: assert property ($changed(periodic_interrupt_timer) |-> $past(rtc_tick)
        || $past(rtc_tick, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2))
        else $error("periodic output moved without a tick");
    AST_DIV_CHAIN: assert property ($changed(div_level_event[1]) && !$past(wb_ack_o)
        && !$past(wb_ack_o, 2) |-> $fell(div_level_event[0]))
        else $error("divide chain out of order");
    AST_IRQ_HOLD: assert property (irq && !$past(wb_we_i) && !wb_we_i |=> irq)
        else $error("interrupt dropped without a write");
    // main scenarios reached
    COV_OVF: cover property (overflow_event);
    COV_CMP: cover property (compare_match_event);
    COV_IRQ: cover property ($fell(irq));
endmodule : rtc_prescaler_pit_properties

bind rtc_prescaler_pit rtc_prescaler_pit_properties props (.*);

/* File: test/rtc_prescaler_pit_test.sv */
// Purpose: register-level regression of prescaler, periodic output and events
// Assumes: partner supplies tick bursts and counts event pulses
// Notes:   ticks stop between bursts so outputs can be compared still
`timescale 1ns/1ps
module rtc_prescaler_pit_test;
    logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, dat_o, q, p0;
    logic tick, ack, irq, ovf, cmp, pit;
    logic [rtc_pkg::EVT_N-1:0] div;
    int fail_count = 0, cmp_count = 0, cycles = 0, ovf_n, cmp_n, o0, c0;
    rtc_prescaler_pit #(.TICK_DIV(1220)) dut (.clk(clk), .rst_n(rst_n), .rtc_tick(tick),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq), .overflow_event(ovf),
        .compare_match_event(cmp), .div_level_event(div), .periodic_interrupt_timer(pit));
    rtc_event_user partner (.clk(clk), .rst_n(rst_n), .run(run), .overflow_event(ovf),
        .compare_match_event(cmp), .rtc_tick(tick), .ovf_n(ovf_n), .cmp_n(cmp_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : check
    // classic cycle: hold until ack sampled, then release
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_o;
        {cyc, stb, we} <= 3'h0;
    endtask : xfer
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
        xfer(1'b0, a, 32'h0000_0000);
        check(n, e, q);
    endtask : rd_chk
    task automatic burst(input int n);
        run <= 1'b1;
        repeat (n * 4) @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : burst
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(rtc_pkg::OFF_PER, 32'h0000_FFFF, "per reset");
        rd_chk(rtc_pkg::OFF_CMP, 32'h0000_0000, "cmp reset");
        rd_chk(8'h40, 32'h0000_0000, "unmapped read");
        xfer(1'b0, rtc_pkg::OFF_PRESC, 32'h0000_0000);
        p0 = q;
        burst(20);
        rd_chk(rtc_pkg::OFF_PRESC, p0, "idle prescaler");
        check("idle levels", 32'h0000_0000, {23'h0, div, pit});
        xfer(1'b1, rtc_pkg::OFF_PITCTRL, {24'h0, rtc_pkg::PERIOD_SIXTEEN_CYCLES, 4'h1});
        burst(150);
        rd_chk(rtc_pkg::OFF_PRESC, {17'h0, p0[14:0] + 15'h0096}, "running prescaler");
        check("sixteen cycle output", {31'h0, q[3]}, {31'h0, pit});
        check("divided levels", {24'h0, q[12:5]}, {24'h0, div});
        for (int c = 3; c <= 14; c++) begin
            xfer(1'b1, rtc_pkg::OFF_PITCTRL, {24'h0, 4'(c), 4'h1});
            burst(37);
            xfer(1'b0, rtc_pkg::OFF_PRESC, 32'h0000_0000);
            check("periodic bit", {31'h0, q[c]}, {31'h0, pit});
        end
        xfer(1'b1, rtc_pkg::OFF_PITCTRL, 32'h0000_0000);
        xfer(1'b1, rtc_pkg::OFF_PER, 32'h0000_0005);
        xfer(1'b1, rtc_pkg::OFF_CMP, 32'h0000_0003);
        xfer(1'b1, rtc_pkg::OFF_CNT, 32'h0000_0000);
        xfer(1'b1, rtc_pkg::OFF_CTRL, 32'h0000_0001);
        {o0, c0} = {ovf_n, cmp_n};
        burst(11);
        check("overflow pulses", 32'h0000_0001, 32'(ovf_n - o0));
        check("compare pulses", 32'h0000_0002, 32'(cmp_n - c0));
        rd_chk(rtc_pkg::OFF_CNT, 32'h0000_0005, "count after wrap");
        rd_chk(rtc_pkg::OFF_STATUS, 32'h0000_0007, "status flags");
        xfer(1'b1, rtc_pkg::OFF_MASK, 32'h0000_0001);
        xfer(1'b1, rtc_pkg::OFF_STATUS, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check("masked irq", 32'h0000_0000, {31'h0, irq});
        xfer(1'b1, rtc_pkg::OFF_MASK, 32'h0000_0002);
        repeat (2) @(posedge clk);
        check("compare irq", 32'h0000_0001, {31'h0, irq});
        xfer(1'b1, rtc_pkg::OFF_STATUS, 32'h0000_0007);
        rd_chk(rtc_pkg::OFF_STATUS, 32'h0000_0000, "cleared flags");
        check("cleared irq", 32'h0000_0000, {31'h0, irq});
        complete_run();
    end
endmodule : rtc_prescaler_pit_test

/* File: verilog/rtc_pkg.sv */
// Purpose: shared constants and types for the real-time counter prescaler block
// Assumes: one clock domain; RTC clock ticks arrive as a one-cycle enable
// Notes:   register offsets are byte addresses on a 32-bit classic Wishbone bus
package rtc_pkg;
    localparam int unsigned PRESC_W      = 15;
    localparam int unsigned CNT_W        = 16;
    localparam int unsigned CLK_HZ       = 40_000_000;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_PITCTRL   = 8'h04;
    localparam logic [7:0] OFF_PER       = 8'h08;
    localparam logic [7:0] OFF_CMP       = 8'h0C;
    localparam logic [7:0] OFF_CNT       = 8'h10;
    localparam logic [7:0] OFF_STATUS    = 8'h14;
    localparam logic [7:0] OFF_MASK      = 8'h18;
    localparam logic [7:0] OFF_PRESC     = 8'h1C;
    // field positions
    localparam int unsigned CTRL_EN_BIT  = 0;
    localparam int unsigned CTRL_PS_LSB  = 4;
    localparam int unsigned PIT_EN_BIT   = 0;
    localparam int unsigned PIT_PER_LSB  = 4;
    localparam int unsigned ST_OVF_BIT   = 0;
    localparam int unsigned ST_CMP_BIT   = 1;
    localparam int unsigned ST_PIT_BIT   = 2;
    // period code n follows prescaler bit n: code 3 gives 16 cycles (bit 3)
    // codes below the base clamp to 4 cycles, codes above the max to 32768
    localparam logic [3:0] PERIOD_SIXTEEN_CYCLES = 4'h3;
    localparam logic [3:0] PERIOD_CODE_MAX       = 4'hD;
    localparam int unsigned PIT_BIT_BASE  = 1;
    localparam int unsigned EVT_LO_BIT    = 5;   // divide by 64
    localparam int unsigned EVT_N         = 8;   // 64..8192
    // reset values
    localparam logic [CNT_W-1:0] PER_RST  = 16'hFFFF;
    localparam logic [CNT_W-1:0] CMP_RST  = 16'h0000;

    typedef struct packed {
        logic                   counter_enable;
        logic [3:0]             prescale_sel;
        logic                   periodic_enable;
        logic [3:0]             period_sel;
        logic [CNT_W-1:0]       per;
        logic [CNT_W-1:0]       cmp;
        logic [2:0]             mask;
    } rtc_cfg_t;

    typedef struct packed {
        logic                   overflow_event;
        logic                   compare_match_event;
        logic [EVT_N-1:0]       div_level_event;
        logic                   periodic_out;
    } rtc_events_t;
endpackage : rtc_pkg

/* File: verilog/rtc_prescaler_pit.sv */
// Purpose: shared prescaler, periodic timer square wave, counter and event outputs
// Assumes: rtc_tick is a one-cycle pulse per RTC clock period, same clock as clk
// Notes:   registers over classic Wishbone, 32-bit data, one-cycle ack
//
// Overview of operation
// - prescaler runs only when either enable set
// - free phase: first tick anywhere within period
// - periodic output toggles every half period
// - sixteen-cycle setting follows prescaler bit three
// - level events divide by 64 to 8192
// - overflow and compare events last one clk cycle
// - overflow after period match clears counter
// - compare event on count after match
// - periodic period selectable 4 to 32768
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module rtc_prescaler_pit #(
    parameter int unsigned TICK_DIV = 1220
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 rtc_tick,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      irq,
    output logic                      overflow_event,
    output logic                      compare_match_event,
    output logic [rtc_pkg::EVT_N-1:0] div_level_event,
    output logic                      periodic_interrupt_timer
);
    // elaboration checks on the parameter and on package sizes the logic relies on
    initial begin
        if (TICK_DIV < 1) $error("TICK_DIV must be at least one");
        if (rtc_pkg::EVT_LO_BIT + rtc_pkg::EVT_N > rtc_pkg::PRESC_W) begin
            $error("divided level taps run past the prescaler");
        end
        if (rtc_pkg::PIT_BIT_BASE < 1) begin
            $error("shortest periodic period must be at least four cycles");
        end
        if (rtc_pkg::PRESC_W > 16) begin
            $error("prescaler wider than the four-bit period select can reach");
        end
    end

    typedef struct packed {
        rtc_pkg::rtc_cfg_t               cfg;
        logic [rtc_pkg::PRESC_W-1:0]     presc;
        logic [rtc_pkg::CNT_W-1:0]       cnt;
        logic [2:0]                      status;
        logic                            pit_prev;
        rtc_pkg::rtc_events_t            ev;
        logic [31:0]                     rdata;
        logic                            ack;
        logic                            irq;
    } state_t;

    state_t s_reg;
    state_t s_next;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // prescaler bit that drives the selected periodic output
    function automatic logic pit_bit(input logic [rtc_pkg::PRESC_W-1:0] p,
                                     input logic [3:0] code);
        logic [3:0] idx;
        // code n taps prescaler bit n, so the sixteen-cycle code taps bit 3
        idx = code;
        // below the base the shortest period of four cycles is kept
        if (code < 4'(rtc_pkg::PIT_BIT_BASE)) idx = 4'(rtc_pkg::PIT_BIT_BASE);
        // above the top code the longest period is kept
        if (code > rtc_pkg::PERIOD_CODE_MAX) idx = 4'(rtc_pkg::PRESC_W - 1);
        return p[idx];
    endfunction : pit_bit

    // counter tick: prescaler bit falling edge for the chosen division
    function automatic logic presc_carry(input logic [rtc_pkg::PRESC_W-1:0] p,
                                         input logic [3:0] sel);
        logic [rtc_pkg::PRESC_W-1:0] mask;
        mask = (rtc_pkg::PRESC_W'(1) << sel) - rtc_pkg::PRESC_W'(1);
        if (sel > 4'hF) mask = '1;
        return (p & mask) == mask;
    endfunction : presc_carry

    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic        run;
        logic        cnt_tick;
        logic        pit_now;
        logic [2:0]  evset;
        logic        wr;
        logic        rd;
        logic [31:0] w;
        s_next = s_reg;
        evset  = 3'b000;
        run    = s_reg.cfg.counter_enable | s_reg.cfg.periodic_enable;
        cnt_tick = 1'b0;
        s_next.ev.overflow_event      = 1'b0;
        s_next.ev.compare_match_event = 1'b0;
        s_next.ack = 1'b0;

        // prescaler: no reset on enable so phase stays free
        if (run && rtc_tick) begin
            s_next.presc = s_reg.presc + rtc_pkg::PRESC_W'(1);
            cnt_tick = s_reg.cfg.counter_enable
                     & presc_carry(s_reg.presc, s_reg.cfg.prescale_sel);
        end

        // counter, overflow and compare
        if (cnt_tick) begin
            if (s_reg.cnt == s_reg.cfg.per) begin
                s_next.cnt = '0;
                s_next.ev.overflow_event = 1'b1;
                evset[rtc_pkg::ST_OVF_BIT] = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + rtc_pkg::CNT_W'(1);
            end
            if (s_reg.cnt == s_reg.cfg.cmp) begin
                s_next.ev.compare_match_event = 1'b1;
                evset[rtc_pkg::ST_CMP_BIT] = 1'b1;
            end
        end

        // periodic output square wave from prescaler bit
        pit_now = s_reg.cfg.periodic_enable & pit_bit(s_next.presc, s_reg.cfg.period_sel);
        s_next.ev.periodic_out = pit_now;
        s_next.pit_prev = pit_now;
        if (pit_now && !s_reg.pit_prev) evset[rtc_pkg::ST_PIT_BIT] = 1'b1;

        // divided level events while prescaler runs
        s_next.ev.div_level_event = run ?
            s_next.presc[rtc_pkg::EVT_LO_BIT +: rtc_pkg::EVT_N] : '0;

        // bus access, single-cycle ack, dropped after one cycle
        wr = wb_cyc_i & wb_stb_i & ~s_reg.ack & wb_we_i;
        rd = wb_cyc_i & wb_stb_i & ~s_reg.ack & ~wb_we_i;
        w  = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
        if (wb_cyc_i && wb_stb_i && !s_reg.ack) s_next.ack = 1'b1;
        if (wr) begin
            case (wb_adr_i)
                rtc_pkg::OFF_CTRL: begin
                    s_next.cfg.counter_enable = w[rtc_pkg::CTRL_EN_BIT];
                    s_next.cfg.prescale_sel   = w[rtc_pkg::CTRL_PS_LSB +: 4];
                end
                rtc_pkg::OFF_PITCTRL: begin
                    s_next.cfg.periodic_enable = w[rtc_pkg::PIT_EN_BIT];
                    s_next.cfg.period_sel      = w[rtc_pkg::PIT_PER_LSB +: 4];
                end
                rtc_pkg::OFF_PER:  s_next.cfg.per = w[rtc_pkg::CNT_W-1:0];
                rtc_pkg::OFF_CMP:  s_next.cfg.cmp = w[rtc_pkg::CNT_W-1:0];
                rtc_pkg::OFF_CNT:  s_next.cnt     = w[rtc_pkg::CNT_W-1:0];
                rtc_pkg::OFF_STATUS: s_next.status = s_reg.status & ~w[2:0];
                rtc_pkg::OFF_MASK: s_next.cfg.mask = w[2:0];
                default: ;
            endcase
        end
        // set wins over clear
        s_next.status = s_next.status | evset;
        s_next.rdata = 32'h0000_0000;
        if (rd) begin
            case (wb_adr_i)
                rtc_pkg::OFF_CTRL: begin
                    s_next.rdata[rtc_pkg::CTRL_EN_BIT]      = s_reg.cfg.counter_enable;
                    s_next.rdata[rtc_pkg::CTRL_PS_LSB +: 4] = s_reg.cfg.prescale_sel;
                end
                rtc_pkg::OFF_PITCTRL: begin
                    s_next.rdata[rtc_pkg::PIT_EN_BIT]       = s_reg.cfg.periodic_enable;
                    s_next.rdata[rtc_pkg::PIT_PER_LSB +: 4] = s_reg.cfg.period_sel;
                end
                rtc_pkg::OFF_PER:    s_next.rdata[15:0] = s_reg.cfg.per;
                rtc_pkg::OFF_CMP:    s_next.rdata[15:0] = s_reg.cfg.cmp;
                rtc_pkg::OFF_CNT:    s_next.rdata[15:0] = s_reg.cnt;
                rtc_pkg::OFF_STATUS: s_next.rdata[2:0]  = s_reg.status;
                rtc_pkg::OFF_MASK:   s_next.rdata[2:0]  = s_reg.cfg.mask;
                rtc_pkg::OFF_PRESC:  s_next.rdata[14:0] = s_reg.presc;
                default:             s_next.rdata       = 32'h0000_0000;
            endcase
        end
        s_next.irq = |(s_next.status & s_next.cfg.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg         <= '0;
            s_reg.cfg.per <= rtc_pkg::PER_RST;
            s_reg.cfg.cmp <= rtc_pkg::CMP_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flip-flops
    assign wb_dat_o                 = s_reg.rdata;
    assign wb_ack_o                 = s_reg.ack;
    assign irq                      = s_reg.irq;
    assign overflow_event           = s_reg.ev.overflow_event;
    assign compare_match_event      = s_reg.ev.compare_match_event;
    assign div_level_event          = s_reg.ev.div_level_event;
    assign periodic_interrupt_timer = s_reg.ev.periodic_out;
endmodule : rtc_prescaler_pit
